/* logic/heater_circuit.sv */
// Per-circuit heat-trace controller: duty selection, trips, alarms and accumulators.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module heater_circuit #(
  parameter int          SECOND_CYCLES = heater_pkg::SOFT_PERIOD_S * heater_pkg::CLK_HZ,
  parameter bit          RELAY_MECH    = 1'b0,
  parameter logic [15:0] SUPPLY_VOLTS  = 16'h00f0,
  parameter logic [4:0]  MODULE_ADDR   = 5'h01
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire heater_pkg::bus_req_type bus,
  output logic [31:0]                 rdata,
  input  wire heater_pkg::meas_type   meas_in,
  output logic                        heater_on,
  output logic                        alarm_relay
);
  import heater_pkg::*;

  localparam int PCT_CYCLES = SECOND_CYCLES / int'(PCT_FULL);

  typedef struct packed {
    meas_type    s1;
    meas_type    s2;
    method_type  method;
    logic [2:0]  trip_en;
    logic        sensor_b_cfg;
    logic [6:0]  clamp;
    logic [6:0]  forced;
    logic [3:0]  cond_prev;
    logic [3:0]  unack;
    logic [2:0]  tripped;
    logic [31:0] pct_cnt;
    logic [6:0]  phase;
    logic [5:0]  sec_cnt;
    logic [4:0]  minute;
    logic [6:0]  soft_duty;
    logic        heater;
    logic        relay;
    logic [4:0]  remain;
    logic [31:0] cycles;
    logic [31:0] amp_sec;
    logic [31:0] amp_hr;
    logic [31:0] watt_sec;
    logic [31:0] watt_hr;
    logic [7:0]  cap_gnd;
    logic [6:0]  cap_cur;
    logic [31:0] rdata;
    logic [1:0]  warm;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  // A resistance outside the plausible band means a broken or open sensor.
  function automatic logic res_bad(input logic [9:0] ohm);
    return (ohm > RES_MAX_OHM) || (ohm < RES_MIN_OHM);
  endfunction

  // Accumulators stop at their bound instead of wrapping to a small value.
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v >= ACC_LIMIT) ? ACC_LIMIT : v + 32'h1;
  endfunction

  function automatic logic [6:0] min_pct(input logic [6:0] a, input logic [6:0] b);
    return (a < b) ? a : b;
  endfunction

  // Percent settings are bounded on the whole word, so 200 stores 100 rather than its low bits.
  function automatic logic [6:0] pct_word(input logic [31:0] w);
    return (w > 32'(PCT_FULL)) ? PCT_FULL : w[6:0];
  endfunction

  logic [3:0]  cond;
  logic [3:0]  new_evt;
  logic [2:0]  trip_set;
  logic [15:0] ack_mask;
  logic        fault_a;
  logic        fault_b;
  logic        no_healthy;
  logic        pct_tick;
  logic        sec_tick;
  logic        min_tick;
  logic [6:0]  clamp_eff;
  logic [6:0]  want;
  logic        on_now;
  logic        timed_mech;
  logic [22:0] watts;

  always_comb begin
    st_nxt = st_r;
    // Two-stage synchronisers for every measurement pin; only stage two is read.
    st_nxt.s1 = meas_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.warm = st_r.warm[1] ? st_r.warm : st_r.warm + 2'h1; // Zeros left by reset are not a dead sensor.

    // Sensor health: the second sensor only counts when it is configured.
    fault_a    = st_r.warm[1] && res_bad(st_r.s2.res_a);
    fault_b    = st_r.warm[1] && st_r.sensor_b_cfg && res_bad(st_r.s2.res_b);
    no_healthy = fault_a && (!st_r.sensor_b_cfg || fault_b);

    // Alarm conditions; a disabled trip still shows up here as an alarm.
    cond = {fault_a || fault_b, st_r.s2.gnd_high, st_r.s2.cur_high, st_r.s2.temp_high};
    new_evt  = cond & ~st_r.cond_prev;
    trip_set = cond[ALM_GND:ALM_TEMP] & st_r.trip_en;
    ack_mask = (bus.wr && bus.addr == REG_ALARM) ? bus.wdata[15:0] : 16'h0000;
    st_nxt.cond_prev = cond;

    // Acknowledge clears, but a fresh event in the same cycle wins.
    st_nxt.unack   = (st_r.unack & ~ack_mask[3:0]) | new_evt;
    st_nxt.tripped = (st_r.tripped & ~ack_mask[2:0]) | trip_set;
    st_nxt.relay   = |st_nxt.unack;

    // Capture the reading that caused a newly set ground or current trip.
    if (trip_set[ALM_GND] && !st_r.tripped[ALM_GND]) begin
      st_nxt.cap_gnd = st_r.s2.ground_ma;
    end
    if (trip_set[ALM_CUR] && !st_r.tripped[ALM_CUR]) begin
      st_nxt.cap_cur = st_r.s2.heater_amps;
    end

    // Time base: percent steps, seconds and minutes.
    pct_tick = (st_r.pct_cnt == 32'(PCT_CYCLES - 1));
    sec_tick = pct_tick && (st_r.phase == PCT_FULL - 7'h01);
    min_tick = sec_tick && (st_r.sec_cnt == 6'(SEC_PER_MIN - 1));
    st_nxt.pct_cnt = pct_tick ? 32'h0 : st_r.pct_cnt + 32'h1;
    if (pct_tick) begin
      st_nxt.phase = (st_r.phase == PCT_FULL - 7'h01) ? 7'h00 : st_r.phase + 7'h01;
    end
    if (sec_tick) begin
      st_nxt.sec_cnt = (st_r.sec_cnt == 6'(SEC_PER_MIN - 1)) ? 6'h00 : st_r.sec_cnt + 6'h01;
    end
    if (min_tick) begin
      st_nxt.minute = (st_r.minute == 5'(WINDOW_MIN - 1)) ? 5'h00 : st_r.minute + 5'h01;
    end

    // Mechanical relays ignore the clamp; they cannot switch fast enough to use it.
    clamp_eff = RELAY_MECH ? PCT_FULL : st_r.clamp;

    // Soft start restarts at the clamp whenever demand drops, then ramps once per second.
    if (!st_r.s2.demand) begin
      st_nxt.soft_duty = clamp_eff;
    end else if (sec_tick && st_r.soft_duty < PCT_FULL) begin
      st_nxt.soft_duty = st_r.soft_duty + 7'h01;
    end

    // Duty requested by the selected method.
    timed_mech = 1'b0;
    case (st_r.method)
      ON_OFF: begin
        want = st_r.s2.demand ? PCT_FULL : 7'h00;
      end
      ON_OFF_SOFT: begin
        // A clamp of 100 or a mechanical relay leaves plain on/off behaviour.
        if (!RELAY_MECH && clamp_eff < PCT_FULL) begin
          want = st_r.s2.demand ? st_r.soft_duty : 7'h00;
        end else begin
          want = st_r.s2.demand ? PCT_FULL : 7'h00;
        end
      end
      PROPORTIONAL, AMBIENT_PROPORTIONAL: begin
        want = min_pct(min_pct(st_r.s2.prop_duty, PCT_FULL), clamp_eff);
        timed_mech = RELAY_MECH; // timed_proportional_mechanical_mode
      end
      default: begin
        want = 7'h00;
      end
    endcase
    if (no_healthy) begin
      want = st_r.forced;
    end

    // Mechanical proportional runs a 20-minute window in whole minutes.
    if (timed_mech && !no_healthy) begin
      on_now = ({st_r.minute, 2'b00} + {2'b00, st_r.minute}) < want;
    end else begin
      on_now = st_r.phase < want;
    end
    if (|st_r.tripped) begin
      on_now = 1'b0;
    end
    st_nxt.heater = on_now;
    st_nxt.remain = (timed_mech && !on_now) ? 5'(WINDOW_MIN) - st_r.minute : 5'h00;

    // Relay cycle count; a write only clears it when it carries the administrator key.
    if (bus.wr && bus.addr == REG_CYCLES && bus.wdata == ADMIN_KEY) begin
      st_nxt.cycles = 32'h0;
    end else if (RELAY_MECH && on_now && !st_r.heater) begin
      st_nxt.cycles = sat_inc(st_r.cycles);
    end

    // Amp-seconds gather each second; whole hours drain out one per clock.
    watts = SUPPLY_VOLTS[15:0] * st_r.s2.heater_amps;
    if (bus.wr && bus.addr == REG_AMPH) begin
      st_nxt.amp_sec = 32'h0;
      st_nxt.amp_hr  = 32'h0;
    end else if (sec_tick && st_r.heater) begin
      st_nxt.amp_sec = st_r.amp_sec + {25'h0, st_r.s2.heater_amps};
    end else if (st_r.amp_sec >= 32'(SEC_PER_HOUR)) begin
      st_nxt.amp_sec = st_r.amp_sec - 32'(SEC_PER_HOUR);
      st_nxt.amp_hr  = sat_inc(st_r.amp_hr);
    end
    if (bus.wr && bus.addr == REG_WATTH) begin
      st_nxt.watt_sec = 32'h0;
      st_nxt.watt_hr  = 32'h0;
    end else if (sec_tick && st_r.heater) begin
      st_nxt.watt_sec = st_r.watt_sec + {9'h0, watts};
    end else if (st_r.watt_sec >= 32'(SEC_PER_HOUR)) begin
      st_nxt.watt_sec = st_r.watt_sec - 32'(SEC_PER_HOUR);
      st_nxt.watt_hr  = sat_inc(st_r.watt_hr);
    end

    // Configuration writes; out-of-range percentages are held at 100.
    if (bus.wr) begin
      case (bus.addr)
        REG_CTRL: begin
          st_nxt.method       = method_type'(bus.wdata[1:0]);
          st_nxt.trip_en      = bus.wdata[4:2];
          st_nxt.sensor_b_cfg = bus.wdata[5];
        end
        REG_CLAMP:  st_nxt.clamp  = pct_word(bus.wdata);
        REG_FORCED: st_nxt.forced = pct_word(bus.wdata);
        default: ;
      endcase
    end

    // Read data stands in the cycle after the strobe only.
    st_nxt.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL:    st_nxt.rdata = {26'h0, st_r.sensor_b_cfg, st_r.trip_en, st_r.method};
        REG_CLAMP:   st_nxt.rdata = {25'h0, st_r.clamp};
        REG_FORCED:  st_nxt.rdata = {25'h0, st_r.forced};
        REG_ALARM:   st_nxt.rdata = {12'h0, st_r.unack, 9'h0, st_r.tripped, st_r.cond_prev};
        REG_STATUS:  st_nxt.rdata = {16'h0, st_r.remain, 1'b0, st_r.heater, st_r.relay, 1'b0, st_r.phase};
        REG_CYCLES:  st_nxt.rdata = st_r.cycles;
        REG_AMPH:    st_nxt.rdata = st_r.amp_hr;
        REG_WATTH:   st_nxt.rdata = st_r.watt_hr;
        REG_CAPTURE: st_nxt.rdata = {8'h0, st_r.cap_gnd, 9'h0, st_r.cap_cur};
        REG_IDENT:   st_nxt.rdata = {RELAY_MECH, 10'h0, MODULE_ADDR, SUPPLY_VOLTS};
        default:     st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // One register bank for the whole state; reset loads constants only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= '0;
      st_r.method <= ON_OFF;
      st_r.clamp  <= CLAMP_RST;
      st_r.forced <= FORCED_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata       = st_r.rdata;
  assign heater_on   = st_r.heater;
  assign alarm_relay = st_r.relay;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_trip_evt;
    st_r.trip_en[ALM_TEMP] && st_r.s2.temp_high;
  endsequence
  sequence s_heater_dark;
    !heater_on [*2];
  endsequence

  AST_ALARM_CODE: assert property (st_r.cond_prev[3:0] == $past(cond))
    else $error("Active alarm code does not track conditions.");
  AST_ACK_RELAY: assert property ((bus.wr && bus.addr == REG_ALARM && bus.wdata[15:0] == 16'hffff && new_evt == 4'h0)
    |=> !alarm_relay)
    else $error("Alarm relay held after acknowledge of all alarms.");
  AST_TRIP_HOLD: assert property (s_trip_evt ##1 (ack_mask[ALM_TEMP] == 1'b0) |-> st_r.tripped[ALM_TEMP])
    else $error("Temperature trip did not latch.");
  AST_TRIP_OFF: assert property (s_trip_evt ##1 !ack_mask[ALM_TEMP] |=> s_heater_dark)
    else $error("Heater energised while tripped.");
  AST_FAULT_FORCED: assert property ((no_healthy && st_r.tripped == 3'h0 && st_r.forced == 7'h00) |=> !heater_on)
    else $error("Heater energised without a healthy sensor.");
  AST_SENSOR_FLAG: assert property ((st_r.s2.res_a > RES_MAX_OHM) |=> st_r.cond_prev[ALM_SENSOR])
    else $error("High sensor resistance not flagged.");
  AST_CLAMP: assert property ((!RELAY_MECH && st_r.method == PROPORTIONAL && st_r.phase >= st_r.clamp && !no_healthy)
    |=> !heater_on)
    else $error("Duty exceeded clamp.");
  AST_REMAIN: assert property (st_r.remain <= 5'(WINDOW_MIN))
    else $error("Remaining minutes out of range.");
  AST_CYCLES_SAT: assert property (st_r.cycles <= ACC_LIMIT && st_r.amp_hr <= ACC_LIMIT)
    else $error("Accumulator passed its bound.");
  AST_GND_CAP: assert property ((trip_set[ALM_GND] && !st_r.tripped[ALM_GND])
    |=> st_r.cap_gnd == $past(st_r.s2.ground_ma))
    else $error("Ground current not captured at trip.");
  AST_READ_ONE: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("Read data outside the read answer cycle.");
endmodule // heater_circuit

/* logic/heater_pkg.sv */
// Package with constants, register map and types for the heater circuit controller.
// What this block does
// - Keep a 4-bit active-alarm code showing which alarm conditions are active now.
// - Acknowledge one or all alarms; alarm relay releases once all are acknowledged.
// - Separate temperature, current, ground trip enables; trip holds until its alarm acknowledged.
// - Control method is on/off, on/off soft start, proportional or ambient proportional.
// - Hold a forced duty 0 to 100 percent applied during a sensor fault.
// - Sensor fault when resistance is above 313 ohms or below 48 ohms.
// - Keep controlling from a healthy second sensor; otherwise heater defaults off.
// - Clamp duty to 0 to 100 percent, except with mechanical relays.
// - Soft start with solid-state relays uses a 1 s period starting at clamp.
// - Soft start with clamp at 100 percent behaves as plain on/off.
// - Count mechanical relay cycles read-only, saturating, cleared only by administrator key.
// - Keep a running amp-hour total since last clear, bounded at 2,147,483,648.
// - Accumulate energy as configured voltage times measured heater current since last clear.
// - Heater voltage is a constant set before shipment, never measured.
// - In timed mechanical proportional mode report minutes 0 to 20 until re-energize.
// - On ground trip capture and hold the ground current reading, 20 to 255 mA.
// - On current trip capture and hold the heater current reading, 1 to 100 A.
// - Each module carries a fixed unique address between 01 and 20.
// - With a trip disabled, top threshold crossing is reported as alarm only.
package heater_pkg;
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          SOFT_PERIOD_S  = 1;
  localparam int          WINDOW_MIN     = 20;
  localparam int          SEC_PER_MIN    = 60;
  localparam int          SEC_PER_HOUR   = 3600;
  localparam logic [6:0]  PCT_FULL       = 7'h64;
  localparam logic [9:0]  RES_MAX_OHM    = 10'h139;
  localparam logic [9:0]  RES_MIN_OHM    = 10'h030;
  localparam logic [31:0] ACC_LIMIT      = 32'h8000_0000;
  localparam logic [31:0] ADMIN_KEY      = 32'h00ad_c1ea;
  // Register word indices.
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_CLAMP      = 4'h1;
  localparam logic [3:0]  REG_FORCED     = 4'h2;
  localparam logic [3:0]  REG_ALARM      = 4'h3;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_CYCLES     = 4'h5;
  localparam logic [3:0]  REG_AMPH       = 4'h6;
  localparam logic [3:0]  REG_WATTH      = 4'h7;
  localparam logic [3:0]  REG_CAPTURE    = 4'h8;
  localparam logic [3:0]  REG_IDENT      = 4'h9;
  // Alarm code bit positions.
  localparam int          ALM_TEMP       = 0;
  localparam int          ALM_CUR        = 1;
  localparam int          ALM_GND        = 2;
  localparam int          ALM_SENSOR     = 3;
  // Reset values.
  localparam logic [6:0]  CLAMP_RST      = 7'h64;
  localparam logic [6:0]  FORCED_RST     = 7'h00;

  typedef enum logic [1:0] {ON_OFF, ON_OFF_SOFT, PROPORTIONAL, AMBIENT_PROPORTIONAL} method_type;

  typedef struct packed {
    logic       temp_high;
    logic       cur_high;
    logic       gnd_high;
    logic       demand;
    logic [6:0] prop_duty;
    logic [9:0] res_a;
    logic [9:0] res_b;
    logic [6:0] heater_amps;
    logic [7:0] ground_ma;
  } meas_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
endpackage

/* test/heater_circuit_tb_top.sv */
// Self-checking bench for one heater circuit controller.
`timescale 1ns/10ps
module heater_circuit_tb_top;
  import heater_pkg::*;
  localparam int SEC = 200;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  bus_req_type bus         = '0;
  meas_type    env         = '0;
  meas_type    meas;
  logic [31:0] rdata;
  logic        heater_on;
  logic        alarm_relay;
  logic [31:0] rdata_m;
  logic [31:0] dm;
  logic        heater_m;
  logic        m_prev      = 1'b0;
  int          n_m;
  int          n_cyc       = 0;
  int          n_mismatch  = 0;
  int          n_tests     = 0;
  logic [31:0] seed        = 32'h5794;
  logic [31:0] d;
  int          n;
  int          ex;
  int          mth[5]      = '{0, 1, 2, 3, 1};
  int          clmp[5]     = '{100, 20, 30, 100, 100};
  int          pd[5]       = '{0, 0, 80, 25, 0};
  int          res_v[4]    = '{314, 47, 313, 48};

  // A short second keeps the duty and accumulator runs brief.
  heater_circuit #(.SECOND_CYCLES(SEC)) dut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .meas_in(meas), .heater_on(heater_on), .alarm_relay(alarm_relay));
  heater_field_model field (.clk(clk), .heater_on(heater_on), .env(env), .meas(meas));

  // Mechanical-relay twin on the same bus and pins; it must ignore the clamp and count closures.
  heater_circuit #(.SECOND_CYCLES(SEC), .RELAY_MECH(1'b1)) dut_mech (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata_m),
    .meas_in(meas), .heater_on(heater_m), .alarm_relay());

  // Clock at 250 MHz.
  always #2 clk = ~clk;

  // Reference count of mechanical relay closures, taken from the relay drive itself.
  always @(posedge clk) begin
    m_prev <= heater_m;
    if (heater_m === 1'b1 && m_prev === 1'b0) n_cyc++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Duty windows are not phase aligned with the design's second, so allow two percent.
  task automatic near(input int got, input int exp);
    check(32'(got >= exp - 4 && got <= exp + 4), 32'h1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
    dm = rdata_m;
  endtask

  task automatic wait_c(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic count_on(output int cnt);
    cnt = 0;
    n_m = 0;
    repeat (SEC) begin
      @(posedge clk);
      #1;
      if (heater_on === 1'b1) cnt++;
      if (heater_m === 1'b1) n_m++;
    end
  endtask

  // Hang guard: a run far past its length counts as broken.
  initial begin
    #240000;
    n_mismatch++;
    give_verdict;
  end

  // Main sequence; expectations come from the settings written here.
  initial begin
    env.res_a = 10'h064;
    env.res_b = 10'h064;
    repeat (6) @(posedge clk);
    check({30'h0, heater_on, alarm_relay}, 32'h0);
    rst_n <= 1'b1;
    wait_c(2);
    rd(REG_CTRL, d);
    check(d, 32'h0);
    rd(REG_CLAMP, d);
    check(d, 32'h64);
    rd(REG_FORCED, d);
    check(d, 32'h0);
    rd(REG_IDENT, d);
    check(d, {11'h000, 5'h01, 16'h00f0});
    rd(4'hf, d);
    check(d, 32'h0);
    wr(REG_CLAMP, 32'hc8);
    rd(REG_CLAMP, d);
    check(d, 32'h64);
    wr(REG_FORCED, 32'h65);
    rd(REG_FORCED, d);
    check(d, 32'h64);
    seed = lfsr(seed);
    wr(REG_CLAMP, seed % 101);
    rd(REG_CLAMP, d);
    check(d, seed % 101);
    // Every control method with its own clamp and law output.
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, 32'(mth[i]));
      wr(REG_CLAMP, 32'(clmp[i]));
      env.prop_duty <= 7'(pd[i]);
      env.demand <= 1'b0;
      wait_c(8);
      env.demand <= 1'b1;
      wait_c(6);
      count_on(n);
      ex = (mth[i] < 2 || pd[i] > clmp[i]) ? clmp[i] : pd[i];
      near(n, ex * SEC / 100);
      // The twin has no clamp and its 20-minute window opens switched on, so it stays on.
      check(n_m, SEC);
    end
    wr(REG_CLAMP, 32'h64);
    wr(REG_CTRL, 32'h0);
    // Sensor range edges.
    for (int i = 0; i < 4; i++) begin
      env.res_a <= 10'(res_v[i]);
      wait_c(6);
      rd(REG_ALARM, d);
      check(32'(d[ALM_SENSOR]), 32'(i < 2));
    end
    env.res_a <= 10'h02f;
    wr(REG_FORCED, 32'h0);
    wait_c(6);
    count_on(n);
    check(n, 0);
    wr(REG_FORCED, 32'h32);
    wait_c(6);
    count_on(n);
    near(n, SEC / 2);
    wr(REG_CTRL, 32'h20);
    wait_c(6);
    count_on(n);
    check(n, SEC);
    env.res_a <= 10'h064;
    wr(REG_CTRL, 32'h0);
    wr(REG_ALARM, 32'hffff);
    // Temperature, current and ground trips in turn.
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      ex = (k == 1) ? 1 + int'(seed % 100) : 20 + int'(seed % 236);
      env.heater_amps <= 7'(1 + seed % 100);
      env.ground_ma <= 8'(20 + seed % 236);
      wr(REG_CTRL, 32'h4 << k);
      wait_c(6);
      {env.temp_high, env.cur_high, env.gnd_high} <= 3'b100 >> k;
      wait_c(6);
      check({heater_on, alarm_relay}, 2'b01);
      rd(REG_CAPTURE, d);
      if (k > 0) check(k == 1 ? 32'(d[6:0]) : 32'(d[23:16]), ex);
      {env.temp_high, env.cur_high, env.gnd_high} <= 3'b000;
      wait_c(6);
      check(heater_on, 1'b0);
      wr(REG_ALARM, 32'hffff);
      wait_c(6);
      check({heater_on, alarm_relay}, 2'b10);
    end
    // A disabled trip only alarms; a single acknowledge frees the relay.
    wr(REG_CTRL, 32'h0);
    env.gnd_high <= 1'b1;
    wait_c(6);
    rd(REG_ALARM, d);
    check(d, 32'h0004_0004);
    check({heater_on, alarm_relay}, 2'b11);
    rd(REG_STATUS, d);
    check(32'(d[15:8]), 32'h03);
    wr(REG_ALARM, 32'h0004);
    wait_c(4);
    check(alarm_relay, 1'b0);
    env.gnd_high <= 1'b0;
    // Accumulators over about 110 seconds at 36 A.
    env.heater_amps <= 7'h24;
    wr(REG_AMPH, 32'h0);
    wr(REG_WATTH, 32'h0);
    rd(REG_AMPH, d);
    check(d, 32'h0);
    wait_c(110 * SEC);
    rd(REG_AMPH, d);
    check(d, 32'h1);
    rd(REG_WATTH, d);
    check(32'(d >= 261 && d <= 268), 32'h1);
    rd(REG_CYCLES, d);
    check(d, 32'h0);
    check(dm, 32'(n_cyc));
    check(32'(n_cyc > 0), 32'h1);
    // A clear without the administrator key must leave the count alone.
    wr(REG_CYCLES, ~ADMIN_KEY);
    rd(REG_CYCLES, d);
    check(dm, 32'(n_cyc));
    wr(REG_CYCLES, ADMIN_KEY);
    rd(REG_CYCLES, d);
    check(dm, 32'h0);
    give_verdict;
  end
endmodule // heater_circuit_tb_top

/* test/heater_field_model.sv */
// Field side model: relay load current and sensor readings seen by the controller.
`timescale 1ns/10ps
module heater_field_model (
  input  wire logic                 clk,
  input  wire logic                 heater_on,
  input  wire heater_pkg::meas_type env,
  output heater_pkg::meas_type      meas
);
  import heater_pkg::*;

  // Load current only flows while the relay is closed, so a trip must hold its captured reading.
  always @(posedge clk) begin
    meas             <= env;
    meas.cur_high    <= env.cur_high & heater_on;
    meas.heater_amps <= heater_on ? env.heater_amps : 7'h00;
  end
endmodule // heater_field_model
